// [rtl/itbu_pkg.sv]
// package: register map, field layout and constants for the interrupt and time base unit
package itbu_pkg;
  localparam int          ITBU_NSRC        = 9;
  // source index order is also service priority, 0 highest
  localparam int          SRC_LOW_SUPPLY   = 0;
  localparam int          SRC_CONV_DONE    = 1;
  localparam int          SRC_NV_WRITE     = 2;
  localparam int          SRC_TMA_CMPA     = 3;
  localparam int          SRC_TMA_CMPP     = 4;
  localparam int          SRC_TMB_CMPA     = 5;
  localparam int          SRC_TMB_CMPP     = 6;
  localparam int          SRC_INTERVAL_0   = 7;
  localparam int          SRC_INTERVAL_1   = 8;
  // byte addresses on the register bus
  localparam logic [5:0]  ADDR_PSC_SEL     = 6'h00;
  localparam logic [5:0]  ADDR_TB0_CTRL    = 6'h04;
  localparam logic [5:0]  ADDR_TB1_CTRL    = 6'h08;
  localparam logic [5:0]  ADDR_REQ_FLAGS   = 6'h0C;
  localparam logic [5:0]  ADDR_SRC_ENABLE  = 6'h10;
  localparam logic [5:0]  ADDR_GLOBAL_CTRL = 6'h14;
  localparam logic [5:0]  ADDR_STACK_CFG   = 6'h18;
  localparam logic [5:0]  ADDR_EVT_STATUS  = 6'h1C;
  localparam logic [5:0]  ADDR_EVT_MASK    = 6'h20;
  localparam logic [5:0]  ADDR_REQ_SET     = 6'h24;
  // field positions
  localparam int          TB_ON_BIT        = 7;
  localparam int          TB_PERIOD_LSB    = 0;
  localparam int          TB_PERIOD_W      = 3;
  localparam int          PSC_SRC_LSB      = 0;
  localparam int          PSC_SRC_W        = 2;
  localparam int          GIE_BIT          = 0;
  localparam int          TB_BASE_EXP      = 8;
  localparam int          TB_CNT_W         = 16;
  // reset values
  localparam logic [7:0]  RST_TB_CTRL      = 8'h00;
  localparam logic [1:0]  RST_PSC_SRC      = 2'h0;
  localparam logic [3:0]  RST_STACK_DEPTH  = 4'h8;
  localparam int          EVT_NUM          = 3;
  localparam int          EVT_WAKE         = 0;
  localparam int          EVT_VECTOR       = 1;
  localparam int          EVT_STACK_BLOCK  = 2;
  localparam logic [1:0]  PSC_SYS          = 2'h0;
  localparam logic [1:0]  PSC_SYS_DIV4     = 2'h1;
endpackage

// [rtl/itbu_top.sv]
// interrupt request, vectoring, wake-up and two time base generators behind a Wishbone slave
`timescale 1ns/1ps
// Contract
// - low supply report sets its request flag
// - conversion done sets its request flag
// - nonvolatile write done sets its flag
// - two timers, A and P flags each
// - vector needs global, source enable, stack room
// - servicing clears source flag and global enable
// - interval overflow sets interval request flag
// - prescaler source: sys, sys/4, sub clock
// - bit 7 on; period 2^(8+n) clocks
// - flag rising edge wakes from sleep/idle
// - wake ignores all enable bits
// - flags stay set until serviced or cleared
// - vector call pushes program counter only
// - return-interrupt sets global enable, return not
// - full stack blocks acknowledge until pop
module itbu_top
  import itbu_pkg::*;
#(
  parameter int PC_W = 13
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [5:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // peripheral event pulses
  input  wire logic               low_supply_detector_i,
  input  wire logic               conv_done_i,
  input  wire logic               nv_write_done_i,
  input  wire logic [1:0]         tm_cmpa_match_i,
  input  wire logic [1:0]         tm_cmpp_match_i,
  input  wire logic               sub_clk_tick_i,
  // cpu core
  input  wire logic               cpu_take_i,
  input  wire logic [PC_W-1:0]    cpu_pc_i,
  input  wire logic               cpu_ret_i,
  input  wire logic               cpu_return_from_interrupt_i,
  input  wire logic               cpu_pop_i,
  input  wire logic               cpu_sleeping_i,
  output logic                    vec_req_o,
  output logic [3:0]              vec_idx_o,
  output logic                    vec_call_o,
  output logic [PC_W-1:0]         push_pc_o,
  output logic                    push_o,
  output logic                    ret_o,
  output logic                    wake_o,
  output logic                    irq_o
);

  logic [ITBU_NSRC-1:0] flag_q;
  logic [ITBU_NSRC-1:0] flag_prev_q;
  logic [ITBU_NSRC-1:0] enable_q;
  logic                 gie_q;
  logic [1:0]           psc_src_q;
  logic [7:0]           tb_ctrl_q [2];
  logic [3:0]           stack_depth_q;
  logic [3:0]           sp_q;
  logic [EVT_NUM-1:0]   evt_status_q;
  logic [EVT_NUM-1:0]   evt_mask_q;
  logic [1:0]           div4_q;
  logic                 psc_tick;
  logic [1:0]           tb_ovf;
  logic [ITBU_NSRC-1:0] hw_set;
  logic [ITBU_NSRC-1:0] sw_clr;
  logic [ITBU_NSRC-1:0] sw_set;
  logic [ITBU_NSRC-1:0] svc_clr;
  logic [ITBU_NSRC-1:0] eligible;
  logic                 stack_full;
  logic                 found;
  logic [3:0]           win_idx;
  logic                 vec_fire;
  logic                 wb_req;
  logic                 wb_wr;
  logic                 wake_evt;
  logic [EVT_NUM-1:0]   evt_set;
  logic [EVT_NUM-1:0]   evt_clr;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

  // prescaler clock: the sub clock arrives as a one-cycle tick already in this domain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div4_q <= 2'h0;
    else if (ce_i)
      div4_q <= div4_q + 2'h1;
  end

  always_comb
  begin
    if (psc_src_q == PSC_SYS)
      psc_tick = 1'b1;
    else if (psc_src_q == PSC_SYS_DIV4)
      psc_tick = (div4_q == 2'h3);
    else
      psc_tick = sub_clk_tick_i;
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_tb
    logic [TB_CNT_W-1:0] cnt_q;
    logic [TB_CNT_W-1:0] last;
    assign last = TB_CNT_W'((32'h1 << (TB_BASE_EXP + 32'(tb_ctrl_q[g][TB_PERIOD_LSB +: TB_PERIOD_W]))) - 32'h1);
    assign tb_ovf[g] = ce_i & tb_ctrl_q[g][TB_ON_BIT] & psc_tick & (cnt_q == last);
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cnt_q <= '0;
      else if (ce_i)
      begin
        if (!tb_ctrl_q[g][TB_ON_BIT])
          cnt_q <= '0;
        else if (tb_ovf[g])
          cnt_q <= '0;
        else if (psc_tick)
          cnt_q <= cnt_q + TB_CNT_W'(1);
      end
    end
  end

  always_comb
  begin
    hw_set = '0;
    hw_set[SRC_LOW_SUPPLY] = low_supply_detector_i;
    hw_set[SRC_CONV_DONE]  = conv_done_i;
    hw_set[SRC_NV_WRITE]   = nv_write_done_i;
    hw_set[SRC_TMA_CMPA]   = tm_cmpa_match_i[0];
    hw_set[SRC_TMA_CMPP]   = tm_cmpp_match_i[0];
    hw_set[SRC_TMB_CMPA]   = tm_cmpa_match_i[1];
    hw_set[SRC_TMB_CMPP]   = tm_cmpp_match_i[1];
    hw_set[SRC_INTERVAL_0] = tb_ovf[0];
    hw_set[SRC_INTERVAL_1] = tb_ovf[1];
  end

  // stack pointer counts words held, stack depth is the limit; full blocks every vector
  assign stack_full = (sp_q >= stack_depth_q);
  assign eligible   = flag_q & enable_q & {ITBU_NSRC{gie_q & ~stack_full}};

  always_comb
  begin
    found   = 1'b0;
    win_idx = 4'h0;
    for (int i = 0; i < ITBU_NSRC; i++)
    begin
      if (eligible[i] && !found)
      begin
        found   = 1'b1;
        win_idx = 4'(i);
      end
    end
  end

  assign vec_req_o = found;
  assign vec_idx_o = win_idx;
  assign vec_fire  = ce_i & found & cpu_take_i;

  always_comb
  begin
    svc_clr = '0;
    if (vec_fire)
      svc_clr[win_idx] = 1'b1;
    sw_clr = '0;
    sw_set = '0;
    if (wb_wr && wb_adr_i == ADDR_REQ_FLAGS)
      sw_clr = ~wb_dat_i[ITBU_NSRC-1:0];
    if (wb_wr && wb_adr_i == ADDR_REQ_SET)
      sw_set = wb_dat_i[ITBU_NSRC-1:0];
  end

  // a hardware set in the same cycle as any clear wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_q <= '0;
    else if (ce_i)
      flag_q <= (flag_q & ~sw_clr & ~svc_clr) | sw_set | hw_set;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_prev_q <= '0;
    else if (ce_i)
      flag_prev_q <= flag_q;
  end

  // wake looks only at flag edges, never at enables; the wake output is gated by the sleep state
  assign wake_evt = |(flag_q & ~flag_prev_q);
  assign wake_o   = ce_i & wake_evt & cpu_sleeping_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gie_q <= 1'b0;
    else if (ce_i)
    begin
      if (vec_fire)
        gie_q <= 1'b0;
      else if (cpu_return_from_interrupt_i)
        gie_q <= 1'b1;
      else if (wb_wr && wb_adr_i == ADDR_GLOBAL_CTRL)
        gie_q <= wb_dat_i[GIE_BIT];
    end
  end

  // stack pointer tracks pushes from vector calls and pops from any return
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sp_q <= 4'h0;
    else if (ce_i)
    begin
      if (vec_fire && !(cpu_pop_i || cpu_ret_i || cpu_return_from_interrupt_i))
        sp_q <= sp_q + 4'h1;
      else if (!vec_fire && (cpu_pop_i || cpu_ret_i || cpu_return_from_interrupt_i) && sp_q != 4'h0)
        sp_q <= sp_q - 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vec_call_o <= 1'b0;
      push_o     <= 1'b0;
      push_pc_o  <= '0;
      ret_o      <= 1'b0;
    end
    else if (ce_i)
    begin
      vec_call_o <= vec_fire;
      push_o     <= vec_fire;
      ret_o      <= cpu_ret_i | cpu_return_from_interrupt_i;
      if (vec_fire)
        push_pc_o <= cpu_pc_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      psc_src_q     <= RST_PSC_SRC;
      tb_ctrl_q[0]  <= RST_TB_CTRL;
      tb_ctrl_q[1]  <= RST_TB_CTRL;
      enable_q      <= '0;
      stack_depth_q <= RST_STACK_DEPTH;
      evt_mask_q    <= '0;
    end
    else if (ce_i && wb_wr)
    begin
      if (wb_adr_i == ADDR_PSC_SEL)
        psc_src_q <= wb_dat_i[PSC_SRC_LSB +: PSC_SRC_W];
      else if (wb_adr_i == ADDR_TB0_CTRL)
        tb_ctrl_q[0] <= wb_dat_i[7:0] & 8'h87;
      else if (wb_adr_i == ADDR_TB1_CTRL)
        tb_ctrl_q[1] <= wb_dat_i[7:0] & 8'h87;
      else if (wb_adr_i == ADDR_SRC_ENABLE)
        enable_q <= wb_dat_i[ITBU_NSRC-1:0];
      else if (wb_adr_i == ADDR_STACK_CFG)
        stack_depth_q <= wb_dat_i[3:0];
      else if (wb_adr_i == ADDR_EVT_MASK)
        evt_mask_q <= wb_dat_i[EVT_NUM-1:0];
    end
  end

  always_comb
  begin
    evt_set = '0;
    evt_set[EVT_WAKE]        = wake_evt;
    evt_set[EVT_VECTOR]      = vec_fire;
    evt_set[EVT_STACK_BLOCK] = gie_q & stack_full & |(flag_q & enable_q);
    evt_clr = '0;
    if (wb_wr && wb_adr_i == ADDR_EVT_STATUS)
      evt_clr = wb_dat_i[EVT_NUM-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_status_q <= '0;
    else if (ce_i)
      evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
  end

  assign irq_o = |(evt_status_q & evt_mask_q);

  // single wait-free answer: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        if (wb_adr_i == ADDR_PSC_SEL)
          wb_dat_o <= 32'(psc_src_q);
        else if (wb_adr_i == ADDR_TB0_CTRL)
          wb_dat_o <= 32'(tb_ctrl_q[0]);
        else if (wb_adr_i == ADDR_TB1_CTRL)
          wb_dat_o <= 32'(tb_ctrl_q[1]);
        else if (wb_adr_i == ADDR_REQ_FLAGS)
          wb_dat_o <= 32'(flag_q);
        else if (wb_adr_i == ADDR_SRC_ENABLE)
          wb_dat_o <= 32'(enable_q);
        else if (wb_adr_i == ADDR_GLOBAL_CTRL)
          wb_dat_o <= {24'h000000, sp_q, 3'h0, gie_q};
        else if (wb_adr_i == ADDR_STACK_CFG)
          wb_dat_o <= 32'(stack_depth_q);
        else if (wb_adr_i == ADDR_EVT_STATUS)
          wb_dat_o <= 32'(evt_status_q);
        else if (wb_adr_i == ADDR_EVT_MASK)
          wb_dat_o <= 32'(evt_mask_q);
        else
          wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  a_service_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_fire |=> !gie_q && !flag_q[$past(win_idx)])
    else $error("service did not clear flag and global enable");
  a_vector_needs_all: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_req_o |-> gie_q && enable_q[vec_idx_o] && flag_q[vec_idx_o] && !stack_full)
    else $error("vector request without all conditions");
  a_full_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    stack_full |-> !vec_req_o)
    else $error("vector request with full stack");
  a_priority_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_req_o |-> ((eligible & ((9'h001 << vec_idx_o) - 9'h001)) == 9'h000))
    else $error("lower priority source chosen");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && flag_q[0] && !svc_clr[0] && !sw_clr[0] |=> flag_q[0])
    else $error("request flag dropped on its own");
  a_hw_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && low_supply_detector_i |=> flag_q[SRC_LOW_SUPPLY])
    else $error("low supply event lost");
  a_return_from_interrupt_enables: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cpu_return_from_interrupt_i && !vec_fire |=> gie_q)
    else $error("return from interrupt left global enable low");
  a_ret_keeps_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cpu_ret_i && !cpu_return_from_interrupt_i && !gie_q && !wb_wr |=> !gie_q)
    else $error("plain return set global enable");
  a_push_pc: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_fire |=> push_o && push_pc_o == $past(cpu_pc_i))
    else $error("pushed value is not the program counter");
  a_wake_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cpu_sleeping_i && $rose(flag_q[SRC_INTERVAL_0]) |-> wake_o)
    else $error("flag rise did not wake");
  a_tb_off_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !tb_ctrl_q[0][TB_ON_BIT] |=> g_tb[0].cnt_q == '0)
    else $error("divider not held at zero while off");
  a_tb_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    tb_ovf[0] |=> flag_q[SRC_INTERVAL_0])
    else $error("interval overflow did not set flag");

  c_vector: cover property (@(posedge clk_i) vec_fire);
  c_nested_block: cover property (@(posedge clk_i) evt_set[EVT_STACK_BLOCK]);
  c_wake: cover property (@(posedge clk_i) wake_o);
  c_tb_ovf: cover property (@(posedge clk_i) tb_ovf[1]);

endmodule // itbu_top

// [verification/itbu_cpu_model.sv]
// cpu core stand-in: takes vectors, supplies the pc and returns after a short service routine
`timescale 1ns/1ps
module itbu_cpu_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bench controls
  input  wire logic        take_en_i,
  input  wire logic        use_ret_i,
  // device side
  input  wire logic        vec_req_i,
  input  wire logic        vec_call_i,
  output logic             cpu_take_o,
  output logic [12:0]      cpu_pc_o,
  output logic             cpu_ret_o,
  output logic             cpu_return_from_interrupt_o
);
  logic [3:0] svc_q;
  // one routine at a time: no take while a call is still being serviced
  assign cpu_take_o = vec_req_i & take_en_i & (svc_q == 4'h0);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      svc_q      <= 4'h0;
      cpu_pc_o   <= 13'h0100;
      cpu_ret_o  <= 1'b0;
      cpu_return_from_interrupt_o <= 1'b0;
    end
    else
    begin
      cpu_pc_o   <= cpu_pc_o + 13'h0001;
      svc_q      <= vec_call_i ? 4'h6 : ((svc_q != 4'h0) ? svc_q - 4'h1 : 4'h0);
      cpu_ret_o  <= (svc_q == 4'h1) & use_ret_i;
      cpu_return_from_interrupt_o <= (svc_q == 4'h1) & ~use_ret_i;
    end
  end
endmodule // itbu_cpu_model

// [verification/tb_top.sv]
// self-checking bench for the interrupt and time base unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import itbu_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sub_clk_tick_i, cpu_sleeping_i;
  logic [5:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rexp, r, seed;
  logic [6:0]  ev;
  logic [12:0] cpu_pc, push_pc_o, pc_seen;
  logic [3:0]  vec_idx_o, vexp;
  logic        cpu_take, cpu_ret, cpu_return_from_interrupt, vec_req_o, vec_call_o, push_o, ret_o, wake_o, irq_o;
  logic        take_en, use_ret, ce, take_pend, ret_pend;
  logic [31:0] rdq[$];
  logic [3:0]  vq[$];
  int          error_cnt, compares, cyc_q, i;

  itbu_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .low_supply_detector_i(ev[0]), .conv_done_i(ev[1]), .nv_write_done_i(ev[2]),
    .tm_cmpa_match_i({ev[5], ev[3]}), .tm_cmpp_match_i({ev[6], ev[4]}), .sub_clk_tick_i(sub_clk_tick_i),
    .cpu_take_i(cpu_take), .cpu_pc_i(cpu_pc), .cpu_ret_i(cpu_ret), .cpu_return_from_interrupt_i(cpu_return_from_interrupt), .cpu_pop_i(1'b0),
    .cpu_sleeping_i(cpu_sleeping_i), .vec_req_o(vec_req_o), .vec_idx_o(vec_idx_o), .vec_call_o(vec_call_o),
    .push_pc_o(push_pc_o), .push_o(push_o), .ret_o(ret_o), .wake_o(wake_o), .irq_o(irq_o));

  itbu_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .take_en_i(take_en), .use_ret_i(use_ret),
    .vec_req_i(vec_req_o), .vec_call_i(vec_call_o), .cpu_take_o(cpu_take), .cpu_pc_o(cpu_pc),
    .cpu_ret_o(cpu_ret), .cpu_return_from_interrupt_o(cpu_return_from_interrupt));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic results;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a read notes its expected data; the monitor compares when ack comes
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    if (!we)
      rdq.push_back(d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= we ? d : 32'h00000000;
    @(posedge clk_i);
    while (!wb_ack_o)
      @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic pulse(input logic [6:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 7'h00;
  endtask

  // one interval generator at the given control value; the wake pulse marks its flag's rise
  task automatic tb_run(input logic [5:0] ctl, input logic [31:0] on, input logic [1:0] src, input int per);
    int n;
    wb(1'b1, ADDR_PSC_SEL, {30'h00000000, src});
    wb(1'b1, ADDR_REQ_FLAGS, 32'h00000000);
    wb(1'b1, ctl, on);
    n = 1;
    while (!wake_o)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK("interval length", 1'b1, (n >= per - 4) && (n <= per + 12))
    wb(1'b1, ctl, 32'h00000000);
  endtask

  always @(posedge clk_i)
  begin
    cyc_q <= cyc_q + 1;
    sub_clk_tick_i <= (cyc_q[1:0] == 2'h0);
    if (cyc_q == 30000)
    begin
      error_cnt++;
      results();
    end
  end

  always @(posedge clk_i)
  begin
    if (wb_ack_o && !wb_we_i)
    begin
      rexp = (rdq.size() > 0) ? rdq.pop_front() : 32'hXXXXXXXX;
      `CHK("read data", rexp, wb_dat_o)
    end
    if (vec_req_o && cpu_take)
    begin
      vexp = (vq.size() > 0) ? vq.pop_front() : 4'hF;
      `CHK("vector index", vexp, vec_idx_o)
      pc_seen = cpu_pc;
    end
    if (vec_call_o)
      `CHK("pushed pc", pc_seen, push_pc_o)
    // strobes follow the edge that took the vector or the return, and nothing else
    if (!rst_i)
    begin
      `CHK("vector call", take_pend, vec_call_o)
      `CHK("push strobe", take_pend, push_o)
      `CHK("return strobe", ret_pend, ret_o)
      if (!cpu_sleeping_i)
        `CHK("wake while awake", 1'b0, wake_o)
    end
    take_pend = vec_req_o && cpu_take;
    ret_pend  = cpu_ret || cpu_return_from_interrupt;
  end

  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 6'h00;
    wb_dat_i = 32'h00000000;
    ev = 7'h00;
    sub_clk_tick_i = 1'b0;
    cpu_sleeping_i = 1'b0;
    take_en = 1'b0;
    use_ret = 1'b0;
    ce = 1'b1;
    take_pend = 1'b0;
    ret_pend = 1'b0;
    seed = 32'h00004376;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_PSC_SEL, 32'h00000000);
    wb(1'b0, ADDR_TB0_CTRL, 32'h00000000);
    wb(1'b0, ADDR_STACK_CFG, 32'h00000008);
    wb(1'b0, 6'h3C, 32'h00000000);
    wb(1'b1, ADDR_TB1_CTRL, 32'h000000FF);
    wb(1'b0, ADDR_TB1_CTRL, 32'h00000087);
    wb(1'b1, ADDR_TB1_CTRL, 32'h00000000);
    r = xs();
    wb(1'b1, ADDR_SRC_ENABLE, r);
    wb(1'b0, ADDR_SRC_ENABLE, r & 32'h000001FF);
    // wake with every enable off, then a flag already high must stay quiet
    cpu_sleeping_i <= 1'b1;
    wb(1'b1, ADDR_SRC_ENABLE, 32'h00000000);
    pulse(7'h02);
    wb(1'b0, ADDR_EVT_STATUS, 32'h00000001);
    wb(1'b1, ADDR_EVT_STATUS, 32'h00000007);
    pulse(7'h02);
    wb(1'b0, ADDR_EVT_STATUS, 32'h00000000);
    wb(1'b1, ADDR_REQ_SET, 32'h00000001);
    wb(1'b1, ADDR_EVT_STATUS, 32'h00000007);
    pulse(7'h01);
    wb(1'b0, ADDR_EVT_STATUS, 32'h00000000);
    pulse(7'h7C);
    wb(1'b0, ADDR_REQ_FLAGS, 32'h0000007F);
    tb_run(ADDR_TB0_CTRL, 32'h00000080, 2'h0, 256);
    tb_run(ADDR_TB0_CTRL, 32'h00000080, 2'h1, 1024);
    tb_run(ADDR_TB0_CTRL, 32'h00000080, 2'h2, 1024);
    tb_run(ADDR_TB1_CTRL, 32'h00000081, 2'h0, 512);
    // awake from here on: flag rises must not raise the wake output
    cpu_sleeping_i <= 1'b0;
    // all seven event sources pending at once
    wb(1'b1, ADDR_REQ_FLAGS, 32'h00000000);
    wb(1'b1, ADDR_SRC_ENABLE, 32'h000001FF);
    pulse(7'h7F);
    for (i = 0; i < 7; i++)
      vq.push_back(i[3:0]);
    take_en <= 1'b1;
    wb(1'b1, ADDR_GLOBAL_CTRL, 32'h00000001);
    repeat (120) @(posedge clk_i);
    `CHK("vectors left", 0, vq.size())
    wb(1'b0, ADDR_REQ_FLAGS, 32'h00000000);
    wb(1'b0, ADDR_GLOBAL_CTRL, 32'h00000001);
    use_ret <= 1'b1;
    vq.push_back(4'h0);
    wb(1'b1, ADDR_REQ_SET, 32'h00000001);
    repeat (20) @(posedge clk_i);
    wb(1'b0, ADDR_GLOBAL_CTRL, 32'h00000000);
    // a full stack blocks an enabled request until room returns
    use_ret <= 1'b0;
    wb(1'b1, ADDR_EVT_STATUS, 32'h00000007);
    wb(1'b1, ADDR_STACK_CFG, 32'h00000000);
    wb(1'b1, ADDR_GLOBAL_CTRL, 32'h00000001);
    wb(1'b1, ADDR_REQ_SET, 32'h00000002);
    repeat (10) @(posedge clk_i);
    wb(1'b0, ADDR_REQ_FLAGS, 32'h00000002);
    wb(1'b0, ADDR_EVT_STATUS, 32'h00000005);
    wb(1'b1, ADDR_EVT_MASK, 32'h00000004);
    `CHK("irq raised", 1'b1, irq_o)
    wb(1'b1, ADDR_EVT_MASK, 32'h00000000);
    `CHK("irq masked", 1'b0, irq_o)
    vq.push_back(4'h1);
    wb(1'b1, ADDR_STACK_CFG, 32'h00000008);
    repeat (20) @(posedge clk_i);
    `CHK("vectors left", 0, vq.size())
    wb(1'b1, ADDR_EVT_STATUS, 32'h00000007);
    wb(1'b1, ADDR_EVT_MASK, 32'h00000007);
    `CHK("irq cleared", 1'b0, irq_o)
    // an event that arrives while the clock enable is low is not taken
    ce <= 1'b0;
    pulse(7'h01);
    ce <= 1'b1;
    wb(1'b0, ADDR_REQ_FLAGS, 32'h00000000);
    results();
  end
endmodule // tb_top
